/* adcop_fifo.sv */
module adcop_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Stream
   adcop_stream_if.buffer_side strm
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int LVL_W = $clog2(DEPTH+1);

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   // Pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH-1)) != 0) begin : g_bad_depth
      $error("adcop_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [LVL_W-1:0] level_ff;

   // Handshake decode
   wire push = strm.fill_valid & strm.fill_ready & ~strm.flush;
   wire pop = strm.drain_valid & strm.drain_ready & ~strm.flush;
   assign strm.fill_ready = (level_ff != LVL_W'(DEPTH));
   assign strm.drain_valid = (level_ff != '0);
   assign strm.drain_data = mem[rd_ptr_ff];
   assign strm.level = level_ff;

   // Storage, no reset needed on the array itself
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= strm.fill_data;
      end
   end

   // Pointers and fill level; flush drops everything held
   always_ff @(posedge clk) begin
      if (!rst_b || strm.flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + PTR_W'(push);
         rd_ptr_ff <= rd_ptr_ff + PTR_W'(pop);
         level_ff <= level_ff + LVL_W'(push) - LVL_W'(pop);
      end
   end
endmodule

/* adcop_host.sv */
module adcop_host
   import adcop_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Result pins seen from the host
   input wire logic busy,
   input wire adcop_code_t conversion_result_bits,
   input wire logic range_exceeded_flag,
   // Captured result
   output adcop_code_t cap_data_ff,
   output logic cap_flag_ff
);
   timeunit 1ns;
   timeprecision 1ps;

   logic busy_ff;
   logic busy_fall;

   // ----------------------------------------------------------------------
   // Capture on busy falling edge
   // ----------------------------------------------------------------------
   // The word is still stable when the next conversion pulls busy low
   assign busy_fall = busy_ff & ~busy;

   // Latch word and flag together so they never come from different samples
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_ff <= 1'b1;
         cap_data_ff <= '0;
         cap_flag_ff <= 1'b0;
      end else begin
         busy_ff <= busy;
         if (busy_fall) begin
            cap_data_ff <= conversion_result_bits;
            cap_flag_ff <= range_exceeded_flag;
         end
      end
   end
endmodule

/* adcop_pkg.sv */
`include "adcop_regs.svh"

package adcop_pkg;
   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef logic [`ADCOP_DATA_MSB:0] adcop_code_t;

   typedef enum logic [1:0] {
      ST_ACQUIRE = 2'b01,
      ST_CONVERT = 2'b10
   } adcop_state_e;
endpackage

/* adcop_port.sv */
// Behaviour
// RQ1: Each rising conversion clock edge starts a conversion and samples the input; here an edge that meets a full buffer is dropped.
// RQ2: Busy is low during conversion, high once finished and acquiring.
// RQ3: The host latches data on busy falling or conversion clock rising.
// RQ4: Results are 14-bit two's complement, highest bit most significant.
// RQ5: Overflow flag is high only for the most positive or negative code.
// RQ6: Zero input sits between the all-zeros and all-ones codes.
// RQ7: Each result reaches the outputs three conversion starts after its sample.
// RQ8: The clock source must keep conversions above the minimum rate.
// RQ9: After a long clockless period an internal timer refreshes stored state.
// RQ10: Overflow flag updates together with the data word it qualifies.
`include "adcop_regs.svh"

module adcop_port
   import adcop_pkg::*;
#(
   parameter int REFRESH_CYC = (`ADCOP_REFRESH_TIME_US * 1000) / `ADCOP_CLK_PERIOD_NS,
   parameter int DEPTH = `ADCOP_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Converter pins
   input wire logic conv_clk,
   input wire logic [`ADCOP_DATA_MSB:0] sample_code,
   // Result pins
   output logic [`ADCOP_DATA_MSB:0] conversion_result_bits,
   output logic range_exceeded_flag,
   output logic busy,
   // Status
   output logic refresh_pulse
);
   // ----------------------------------------------------------------------
   // Constants and checks
   // ----------------------------------------------------------------------
   // Conversion time is a least time, so round up
   localparam int CONV_CYC =
      (`ADCOP_CONV_TIME_NS + `ADCOP_CLK_PERIOD_NS - 1) / `ADCOP_CLK_PERIOD_NS;
   localparam int CNT_W = $clog2(CONV_CYC + 1);
   localparam int IDLE_W = $clog2(REFRESH_CYC + 1);
   localparam int LVL_W = $clog2(DEPTH + 1);

   if (DEPTH < `ADCOP_LATENCY + 1 || REFRESH_CYC < 2) begin : g_bad_param
      $error("adcop_port needs a deeper buffer or a longer refresh period");
   end

   // Extreme code detector, shared by the flag and its checks
   function automatic logic is_extreme(input adcop_code_t code);
      is_extreme = (code == `ADCOP_CODE_MOST_POS) || (code == `ADCOP_CODE_MOST_NEG);
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic conv_meta_ff;
   logic conv_sync_ff;
   logic conv_prev_ff;
   adcop_code_t samp_meta_ff;
   adcop_code_t samp_sync_ff;

   // Sample word runs through the same depth as the clock, so they stay aligned
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         conv_meta_ff <= 1'b0;
         conv_sync_ff <= 1'b0;
         conv_prev_ff <= 1'b0;
         samp_meta_ff <= `ADCOP_DATA_RST;
         samp_sync_ff <= `ADCOP_DATA_RST;
      end else begin
         conv_meta_ff <= conv_clk;
         conv_sync_ff <= conv_meta_ff;
         conv_prev_ff <= conv_sync_ff;
         samp_meta_ff <= sample_code;
         samp_sync_ff <= samp_meta_ff;
      end
   end

   // ----------------------------------------------------------------------
   // Pipeline buffer
   // ----------------------------------------------------------------------
   adcop_stream_if #(.WIDTH(`ADCOP_DATA_W), .DEPTH(DEPTH)) strm ();

   adcop_fifo #(.WIDTH(`ADCOP_DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .strm(strm)
   );

   adcop_state_e state_ff;
   adcop_state_e nxt_state;
   logic [CNT_W-1:0] conv_cnt_ff;
   logic [CNT_W-1:0] nxt_conv_cnt;
   logic [IDLE_W-1:0] idle_ff;
   logic [IDLE_W-1:0] nxt_idle;
   logic refresh_ff;

   // Start detection; a full buffer drops the start, and its sample word is lost
   wire start_edge = conv_sync_ff & ~conv_prev_ff; // RQ1
   wire start_taken = start_edge & strm.fill_ready; // RQ1
   wire conv_done = (state_ff == ST_CONVERT) && (conv_cnt_ff == '0) && !start_edge;
   // Hold back until the two later samples are in flight
   wire pop = conv_done & (strm.level >= LVL_W'(`ADCOP_LATENCY)); // RQ7
   wire idle_limit = (idle_ff == IDLE_W'(REFRESH_CYC - 1));
   wire idle_sat = (idle_ff == IDLE_W'(REFRESH_CYC));

   assign strm.fill_valid = start_edge;
   assign strm.fill_data = samp_sync_ff; // RQ1
   assign strm.drain_ready = pop;
   assign strm.flush = idle_limit & ~start_edge; // RQ9

   // ----------------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------------
   // A taken start always restarts the conversion timer
   always_comb begin
      nxt_state = state_ff;
      nxt_conv_cnt = conv_cnt_ff;
      unique case (state_ff)
         ST_ACQUIRE: begin
            if (start_taken) begin
               nxt_state = ST_CONVERT;
               nxt_conv_cnt = CNT_W'(CONV_CYC - 1);
            end
         end
         ST_CONVERT: begin
            if (start_taken) begin
               nxt_conv_cnt = CNT_W'(CONV_CYC - 1);
            end else if (conv_done) begin
               nxt_state = ST_ACQUIRE;
            end else begin
               nxt_conv_cnt = conv_cnt_ff - CNT_W'(1);
            end
         end
      endcase
   end

   // Idle timer parks one past the limit, so a stopped clock flushes and refreshes once
   assign nxt_idle = start_edge ? '0 : (idle_sat ? idle_ff : idle_ff + IDLE_W'(1));

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= ST_ACQUIRE;
         conv_cnt_ff <= '0;
         idle_ff <= '0;
         refresh_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         conv_cnt_ff <= nxt_conv_cnt;
         idle_ff <= nxt_idle; // RQ9
         refresh_ff <= strm.flush & ~refresh_ff & (idle_ff != nxt_idle); // RQ9
      end
   end

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   // Word and flag load in one edge so a capture never sees them split
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         conversion_result_bits <= `ADCOP_DATA_RST;
         range_exceeded_flag <= 1'b0;
         busy <= 1'b1;
         refresh_pulse <= 1'b0;
      end else begin
         if (pop) begin
            // Word passes unaltered: two's complement, zero at midscale
            conversion_result_bits <= strm.drain_data; // RQ4 RQ6
            range_exceeded_flag <= is_extreme(strm.drain_data); // RQ5 RQ10
         end
         // Busy low from start until the conversion timer expires
         busy <= (nxt_state == ST_ACQUIRE); // RQ2
         refresh_pulse <= refresh_ff;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_START_BUSY_LOW: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
      start_taken |=> !busy && state_ff == ST_CONVERT)
      else $error("start edge did not begin a conversion");

   AST_BUSY_TRACKS_CONV: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
      $fell(busy) |-> !busy[*8])
      else $error("busy rose before conversion time elapsed");

   AST_BUSY_RISE_DONE: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
      $rose(busy) |-> $past(conv_done))
      else $error("busy rose without a finished conversion");

   AST_WORD_FROM_BUFFER: assert property (@(posedge clk) disable iff (!rst_b) // RQ4
      pop |=> conversion_result_bits == $past(strm.drain_data))
      else $error("result word differs from buffered sample");

   AST_FLAG_EXTREME: assert property (@(posedge clk) disable iff (!rst_b) // RQ5
      range_exceeded_flag == is_extreme(conversion_result_bits))
      else $error("overflow flag does not match the output code");

   AST_ZERO_MIDSCALE: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
      pop && strm.drain_data == '0 |=> conversion_result_bits == '0 && !range_exceeded_flag)
      else $error("zero sample not presented as zero code");

   AST_LATENCY_THREE: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
      pop |-> strm.level >= LVL_W'(`ADCOP_LATENCY) && conv_done)
      else $error("result released before three starts");

   AST_REFRESH_FIRES: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
      strm.flush && !refresh_ff && idle_ff != nxt_idle |=> refresh_ff ##1 refresh_pulse)
      else $error("refresh did not follow the idle period");

   AST_REFRESH_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
      refresh_pulse |=> !refresh_pulse)
      else $error("refresh pulse longer than one cycle");

   AST_FLUSH_ONCE: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
      strm.flush |=> !strm.flush)
      else $error("pipeline flush repeated while idle");

   AST_BUSY_MATCHES_STATE: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
      busy == (state_ff == ST_ACQUIRE))
      else $error("busy level disagrees with conversion state");

   AST_FLAG_WITH_WORD: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
      $changed(range_exceeded_flag) || $changed(conversion_result_bits) |-> $past(pop))
      else $error("flag or word changed without a result load");
endmodule

/* adcop_port_bench.sv */
module adcop_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import adcop_pkg::*;

   localparam int REFRESH = 50;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic conv_clk = 1'b0;
   adcop_code_t sample_code = '0;
   adcop_code_t result;
   adcop_code_t cap_data;
   logic flag;
   logic busy;
   logic refresh_pulse;
   logic cap_flag;
   int n_mismatch = 0;
   int comparisons = 0;
   adcop_code_t hist[$];

   // ----------------------------------------------------------------------
   // Clock, design and host
   // ----------------------------------------------------------------------
   always #5 clk = ~clk;

   adcop_port #(.REFRESH_CYC(REFRESH), .DEPTH(16)) dut (
      .clk(clk), .rst_b(rst_b), .conv_clk(conv_clk), .sample_code(sample_code),
      .conversion_result_bits(result), .range_exceeded_flag(flag), .busy(busy),
      .refresh_pulse(refresh_pulse)
   );

   adcop_host host (
      .clk(clk), .rst_b(rst_b), .busy(busy), .conversion_result_bits(result),
      .range_exceeded_flag(flag), .cap_data_ff(cap_data), .cap_flag_ff(cap_flag)
   );

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic extreme(input adcop_code_t c);
      return (c == 14'h1fff) || (c == 14'h2000);
   endfunction

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t ns: %s", $time, msg);
      end
   endtask

   // One conversion clock period of 19 cycles, far above the minimum conversion rate
   task automatic conv(input adcop_code_t code);
      @(posedge clk);
      conv_clk <= 1'b1;
      sample_code <= code;
      hist.push_back(code);
      repeat (6) @(negedge clk);
      chk(busy === 1'b0, "busy not low while converting");
      repeat (4) @(posedge clk);
      conv_clk <= 1'b0;
      repeat (10) @(negedge clk);
      chk(busy === 1'b1, "busy not high while acquiring");
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Extremes back to back, midscale pair, near-extremes and an ordinary code
   task automatic run_stream();
      adcop_code_t codes[8];
      codes = '{14'h1fff, 14'h2000, 14'h0000, 14'h3fff, 14'h1ffe, 14'h2001, 14'h0a5c, 14'h1fff};
      hist.delete();
      foreach (codes[i]) begin
         conv(codes[i]);
         if (i < 2) begin
            chk(result === 14'h0000, "word released while pipeline fills");
         end else begin
            chk(result === hist[i-2], "result word mismatch");
            chk(flag === extreme(hist[i-2]), "range flag mismatch");
         end
         if (i >= 3) begin
            chk(cap_data === hist[i-3], "host capture mismatch");
            chk(cap_flag === extreme(hist[i-3]), "host flag mismatch");
         end
      end
   endtask

   // Stop the conversion clock, then rebuild the pipeline after the flush
   task automatic run_refresh();
      adcop_code_t held;
      int k;
      held = result;
      k = 0;
      while (refresh_pulse !== 1'b1 && k < 3 * REFRESH) begin
         @(negedge clk);
         k++;
      end
      chk(refresh_pulse === 1'b1, "no refresh after idle span");
      chk(k >= REFRESH - 25 && k <= REFRESH - 5, "refresh at wrong time");
      @(negedge clk);
      chk(refresh_pulse === 1'b0, "refresh pulse too long");
      chk(result === held, "word changed by refresh");
      hist.delete();
      conv(14'h0777);
      conv(14'h2000);
      chk(result === held, "stale word released after flush");
      conv(14'h1234);
      chk(result === 14'h0777 && flag === 1'b0, "first word after flush wrong");
   endtask

   // ----------------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk(result === 14'h0000 && flag === 1'b0 && busy === 1'b1, "reset state wrong");
      chk(refresh_pulse === 1'b0, "refresh pulse in reset");
      repeat (3) @(posedge clk);
      run_stream();
      run_refresh();
      wrap_up();
   end

   // The tests take well under 1000 cycles; five times that means a hang
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      $display("Error at %0t ns: watchdog expired", $time);
      wrap_up();
   end
endmodule

/* adcop_regs.svh */
`ifndef ADCOP_REGS_SVH
`define ADCOP_REGS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ADCOP_CLK_PERIOD_NS 10
`define ADCOP_CONV_TIME_NS 100
`define ADCOP_REFRESH_TIME_US 1000
`define ADCOP_LATENCY 3

// ----------------------------------------------------------------------
// Data word layout and reset values
// ----------------------------------------------------------------------
`define ADCOP_DATA_W 14
`define ADCOP_DATA_MSB 13
`define ADCOP_CODE_MOST_POS 14'h1fff
`define ADCOP_CODE_MOST_NEG 14'h2000
`define ADCOP_DATA_RST 14'h0000
`define ADCOP_FIFO_DEPTH 16

`endif

/* adcop_stream_if.sv */
// ----------------------------------------------------------------------
// Sample stream between the front end and the pipeline buffer
// ----------------------------------------------------------------------
interface adcop_stream_if #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
);
   logic fill_valid;
   logic fill_ready;
   logic [WIDTH-1:0] fill_data;
   logic drain_valid;
   logic drain_ready;
   logic [WIDTH-1:0] drain_data;
   logic [$clog2(DEPTH+1)-1:0] level;
   logic flush;

   modport buffer_side (
      input fill_valid, fill_data, drain_ready, flush,
      output fill_ready, drain_valid, drain_data, level
   );
   modport user_side (
      output fill_valid, fill_data, drain_ready, flush,
      input fill_ready, drain_valid, drain_data, level
   );
endinterface
